// ==== brd_commander.sv ====
`timescale 1ns/1ns
`default_nettype none
module brd_commander (
	input wire logic mclk,
	input wire logic [1:0] busPhase,
	input wire logic [1:0] confirmationCode,
	input wire logic busFault,
	output logic [31:0] busInfo,
	output logic [2:0] busTag,
	output logic [4:0] busId,
	output logic [3:0] busMask,
	output logic [1:0] busParity
);
	typedef struct packed {
		logic [1:0] bad;
		logic [2:0] tag;
		logic [4:0] id;
		logic [3:0] mask;
		logic [31:0] info;
	} brd_fmt_t;
	brd_fmt_t fmtQ[$];
	logic [1:0] cnf[8];
	logic flt[8];
	int strayCnf = 0;
	initial begin
		{busParity, busTag, busId, busMask, busInfo} = '0;
	end
	task automatic add(input logic [2:0] tag, input logic [31:0] info, input logic [4:0] id,
		input logic [3:0] mask, input logic [1:0] bad);
		fmtQ.push_back({bad, tag, id, mask, info});
	endtask
	// queued formats go out in back-to-back T3 cycles; each answer shows two T0 cycles later
	task automatic run();
		int n;
		int seen;
		logic drove;
		brd_fmt_t f;
		n = fmtQ.size();
		seen = 0;
		drove = 1'b0;
		while (seen < n + 1) begin
			@(posedge mclk);
			if (busPhase == brd_pkg::BRD_T2 && fmtQ.size() > 0) begin
				f = fmtQ.pop_front();
				{busTag, busId, busMask, busInfo} <= {f.tag, f.id, f.mask, f.info};
				busParity <= {^{f.info[31:16], f.mask, f.id, f.tag}, ^f.info[15:0]} ^ f.bad;
				drove = 1'b1;
			end else if (busPhase == brd_pkg::BRD_T3 && drove) begin
				// a released bus must not keep showing the last format
				{busParity, busTag, busId, busMask, busInfo} <=
					~{busParity, busTag, busId, busMask, busInfo};
				drove = 1'b0;
			end else if (busPhase == brd_pkg::BRD_T0 && fmtQ.size() < n) begin
				if (seen > 0) begin
					cnf[seen - 1] = confirmationCode;
					flt[seen - 1] = busFault;
				end
				seen++;
			end
		end
	endtask
	always @(posedge mclk)
		if (busPhase != brd_pkg::BRD_T0 && (confirmationCode != 2'h0 || busFault))
			strayCnf <= strayCnf + 1;
endmodule // brd_commander
`default_nettype wire

// ==== brd_decoder.sv ====
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module brd_decoder #(
	parameter int FILE_DEPTH = 4
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [brd_pkg::APB_ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [brd_pkg::INFO_W-1:0] busInfo,
	input wire logic [brd_pkg::TAG_W-1:0] busTag,
	input wire logic [brd_pkg::ID_W-1:0] busId,
	input wire logic [brd_pkg::MASK_W-1:0] busMask,
	input wire logic [brd_pkg::PAR_W-1:0] busParity,
	output logic [1:0] busPhase,
	output logic [1:0] confirmationCode,
	output logic busFault,
	output logic interlockFlag,
	output logic fileValid,
	input wire logic fileReady,
	output logic fileIsData,
	output logic fileDataAbort,
	output logic fileWriteAbort,
	output logic [1:0] fileDest,
	output logic [brd_pkg::FUNC_W-1:0] fileFunc,
	output logic [brd_pkg::MASK_W-1:0] fileMask,
	output logic [brd_pkg::ID_W-1:0] fileId,
	output logic [brd_pkg::INFO_W-1:0] fileInfo
);
	localparam int PTR_W = $clog2(FILE_DEPTH);
	localparam int NIBBLES = brd_pkg::CHK_W / brd_pkg::NIBBLE_W;
	localparam logic [PTR_W:0] DEPTH_L = (PTR_W + 1)'(FILE_DEPTH);

	typedef struct packed {
		brd_pkg::brd_phase_t phase;
		logic [brd_pkg::INFO_W-1:0] latInfo;
		logic [brd_pkg::TAG_W-1:0] latTag;
		logic [brd_pkg::ID_W-1:0] latId;
		logic [brd_pkg::MASK_W-1:0] latMask;
		logic [brd_pkg::PAR_W-1:0] latPar;
		logic [1:0] pending;
		logic [1:0] ignoreCount;
		logic ilkClear;
		logic interlock;
		logic block;
		logic [1:0] cnfDecided;
		logic faultDecided;
		logic [1:0] cnfStage;
		logic faultStage;
		logic [1:0] cnfOut;
		logic faultOut;
		logic [PTR_W:0] wrPtr;
		logic [PTR_W:0] rdPtr;
		brd_pkg::brd_entry_t [FILE_DEPTH-1:0] file;
		logic [31:0] ctrl;
		logic [31:0] arrayBase;
		logic [31:0] arrayLimit;
		logic [31:0] cfgBase;
		logic [31:0] romBase;
		logic [brd_pkg::ID_W-1:0] readId;
		logic [31:0] prdata;
		logic pslverr;
	} brd_state_t;

	brd_state_t s;
	brd_state_t next_s;

	logic [brd_pkg::CHK_W-1:0] chkVec;
	logic [NIBBLES-1:0] nibPar;
	logic parOk;
	logic isCmd;
	logic isWd;
	logic [brd_pkg::ADDR_W-1:0] addr;
	logic [brd_pkg::FUNC_W-1:0] funcCode;
	brd_pkg::brd_dest_t dest;
	logic funcOk;
	logic [1:0] wrCount;
	logic [PTR_W:0] fillCount;
	logic [PTR_W:0] freeSlots;
	logic [PTR_W:0] needSlots;
	logic spaceOk;
	logic decide;
	logic popFire;
	logic apbSetup;
	logic apbAccess;

	// one parity bit per nibble; the high parity line covers the upper nibbles
	assign chkVec = {s.latTag, s.latId, s.latMask, s.latInfo};
	for (genvar i = 0; i < NIBBLES; i++) begin : g_nib
		assign nibPar[i] = ^chkVec[i*brd_pkg::NIBBLE_W +: brd_pkg::NIBBLE_W];
	end
	assign parOk = !(^nibPar[NIBBLES-1:brd_pkg::LOW_NIBBLES] ^ s.latPar[1])
		&& !(^nibPar[brd_pkg::LOW_NIBBLES-1:0] ^ s.latPar[0]);

	assign isCmd = (s.latTag == brd_pkg::TAG_CMD);
	assign isWd = (s.latTag == brd_pkg::TAG_WDATA);
	assign addr = s.latInfo[brd_pkg::ADDR_W-1:0];
	assign funcCode = s.latInfo[brd_pkg::FUNC_LSB +: brd_pkg::FUNC_W];

	// exactly one destination, or none; bit 27 splits i/o from storage space
	always_comb begin
		dest = brd_pkg::DST_NONE;
		if (addr[brd_pkg::IO_SPACE_BIT]) begin
			if (addr[brd_pkg::IO_SPACE_BIT-1:brd_pkg::CFG_SPAN_BITS]
				== s.cfgBase[brd_pkg::IO_SPACE_BIT-1:brd_pkg::CFG_SPAN_BITS]) begin
				dest = brd_pkg::DST_CFG;
			end else if (addr[brd_pkg::IO_SPACE_BIT-1:brd_pkg::ROM_SPAN_BITS]
				== s.romBase[brd_pkg::IO_SPACE_BIT-1:brd_pkg::ROM_SPAN_BITS]) begin
				dest = brd_pkg::DST_ROM;
			end
		end else if (addr >= s.arrayBase[brd_pkg::ADDR_W-1:0]
			&& addr < s.arrayLimit[brd_pkg::ADDR_W-1:0]) begin
			dest = brd_pkg::DST_ARRAY;
		end
	end

	assign funcOk = brd_pkg::brd_func_valid(funcCode, dest, s.latMask);
	assign wrCount = brd_pkg::brd_write_count(funcCode);
	assign fillCount = s.wrPtr - s.rdPtr;
	assign freeSlots = DEPTH_L - fillCount;
	// space for the command and every write data word is reserved up front
	assign needSlots = (PTR_W + 1)'(wrCount) + (PTR_W + 1)'(1);
	assign spaceOk = (freeSlots >= needSlots);
	assign decide = (s.phase == brd_pkg::BRD_T0) && s.ctrl[brd_pkg::CTRL_ENABLE_BIT];
	assign popFire = fileValid && fileReady;
	assign apbSetup = psel && !penable;
	assign apbAccess = psel && penable;

	always_comb begin
		brd_pkg::brd_entry_t ent;
		logic push;
		logic [31:0] statusWord;
		ent = '0;
		push = 1'b0;
		statusWord = '0;
		next_s = s;
		case (s.phase)
			brd_pkg::BRD_T0: next_s.phase = brd_pkg::BRD_T1;
			brd_pkg::BRD_T1: next_s.phase = brd_pkg::BRD_T2;
			brd_pkg::BRD_T2: next_s.phase = brd_pkg::BRD_T3;
			brd_pkg::BRD_T3: next_s.phase = brd_pkg::BRD_T0;
			default: next_s.phase = brd_pkg::BRD_T0;
		endcase
		// every format is latched, memory bound or not
		if (s.phase == brd_pkg::BRD_T3) begin
			next_s.latInfo = busInfo;
			next_s.latTag = busTag;
			next_s.latId = busId;
			next_s.latMask = busMask;
			next_s.latPar = busParity;
		end
		// confirmation is staged at T2 and shown for the T0 cycle only
		if (s.phase == brd_pkg::BRD_T1) begin
			next_s.cnfStage = s.cnfDecided;
			next_s.faultStage = s.faultDecided;
		end
		next_s.cnfOut = (s.phase == brd_pkg::BRD_T3) ? s.cnfStage : brd_pkg::CNF_NORESP;
		next_s.faultOut = (s.phase == brd_pkg::BRD_T3) && s.faultStage;
		if (popFire) begin
			next_s.rdPtr = s.rdPtr + (PTR_W + 1)'(1);
			next_s.block = 1'b0;
		end
		if (decide) begin
			ent.info = s.latInfo;
			ent.mask = s.latMask;
			ent.id = s.latId;
			ent.func = funcCode;
			ent.dest = dest;
			next_s.cnfDecided = brd_pkg::CNF_NORESP;
			next_s.faultDecided = !parOk && (isCmd || isWd);
			if (s.pending != 2'h0) begin
				ent.isData = 1'b1;
				push = 1'b1;
				if (isWd) begin
					ent.dataAbort = !parOk;
					next_s.pending = s.pending - 2'h1;
					next_s.cnfDecided = brd_pkg::CNF_ACK;
					if (s.ilkClear) begin
						next_s.ilkClear = 1'b0;
						next_s.interlock = 1'b0;
					end
				end else begin
					ent.writeAbort = 1'b1;
					next_s.pending = 2'h0;
				end
			end else if (isWd) begin
				// unexpected data is dropped; data of a discarded command is counted off
				if (s.ignoreCount != 2'h0) begin
					next_s.ignoreCount = s.ignoreCount - 2'h1;
				end
			end else if (isCmd) begin
				next_s.ignoreCount = 2'h0;
				if (!parOk) begin
					next_s.ignoreCount = wrCount;
				end else if (dest == brd_pkg::DST_NONE) begin
					next_s.cnfDecided = brd_pkg::CNF_NORESP;
				end else if (!funcOk) begin
					next_s.cnfDecided = brd_pkg::CNF_ERR;
				end else if (s.block || !spaceOk || (funcCode == brd_pkg::FN_IRM && s.interlock)) begin
					next_s.cnfDecided = brd_pkg::CNF_BUSY;
					if (!spaceOk) begin
						next_s.block = 1'b1;
					end
				end else begin
					push = 1'b1;
					next_s.cnfDecided = brd_pkg::CNF_ACK;
					next_s.pending = wrCount;
					if (funcCode == brd_pkg::FN_IWM) begin
						next_s.ilkClear = 1'b1;
					end
					if (funcCode == brd_pkg::FN_IRM) begin
						next_s.interlock = 1'b1;
					end
					if (funcCode == brd_pkg::FN_RM || funcCode == brd_pkg::FN_IRM
						|| funcCode == brd_pkg::FN_XR) begin
						next_s.readId = s.latId;
					end
				end
			end
		end
		if (push) begin
			next_s.file[s.wrPtr[PTR_W-1:0]] = ent;
			next_s.wrPtr = s.wrPtr + (PTR_W + 1)'(1);
		end
		statusWord[brd_pkg::ST_PEND_LSB +: 2] = s.pending;
		statusWord[brd_pkg::ST_ILKCLR_BIT] = s.ilkClear;
		statusWord[brd_pkg::ST_ILK_BIT] = s.interlock;
		statusWord[brd_pkg::ST_BLOCK_BIT] = s.block;
		statusWord[brd_pkg::ST_COUNT_LSB +: PTR_W + 1] = fillCount;
		statusWord[brd_pkg::ST_CNF_LSB +: 2] = s.cnfDecided;
		// read data is fetched in setup so the access phase needs no wait
		if (apbSetup) begin
			next_s.pslverr = 1'b0;
			case (paddr)
				brd_pkg::REG_CTRL: next_s.prdata = s.ctrl;
				brd_pkg::REG_ARRAY_BASE: next_s.prdata = s.arrayBase;
				brd_pkg::REG_ARRAY_LIMIT: next_s.prdata = s.arrayLimit;
				brd_pkg::REG_CFG_BASE: next_s.prdata = s.cfgBase;
				brd_pkg::REG_ROM_BASE: next_s.prdata = s.romBase;
				brd_pkg::REG_STATUS: next_s.prdata = statusWord;
				brd_pkg::REG_READ_ID: next_s.prdata = 32'(s.readId);
				default: begin
					next_s.prdata = '0;
					next_s.pslverr = 1'b1;
				end
			endcase
		end
		if (apbAccess && pwrite && !s.pslverr) begin
			case (paddr)
				brd_pkg::REG_CTRL: next_s.ctrl = pwdata;
				brd_pkg::REG_ARRAY_BASE: next_s.arrayBase = pwdata;
				brd_pkg::REG_ARRAY_LIMIT: next_s.arrayLimit = pwdata;
				brd_pkg::REG_CFG_BASE: next_s.cfgBase = pwdata;
				brd_pkg::REG_ROM_BASE: next_s.romBase = pwdata;
				default: next_s.ctrl = s.ctrl;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			s <= '0;
			s.ctrl <= brd_pkg::CTRL_RESET;
			s.arrayBase <= brd_pkg::ARRAY_BASE_RESET;
			s.arrayLimit <= brd_pkg::ARRAY_LIMIT_RESET;
			s.cfgBase <= brd_pkg::CFG_BASE_RESET;
			s.romBase <= brd_pkg::ROM_BASE_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign prdata = s.prdata;
	assign pready = apbAccess;
	assign pslverr = apbAccess && s.pslverr;
	assign busPhase = s.phase;
	assign confirmationCode = s.cnfOut;
	assign busFault = s.faultOut;
	assign interlockFlag = s.interlock;
	assign fileValid = (s.wrPtr != s.rdPtr);
	assign fileIsData = s.file[s.rdPtr[PTR_W-1:0]].isData;
	assign fileDataAbort = s.file[s.rdPtr[PTR_W-1:0]].dataAbort;
	assign fileWriteAbort = s.file[s.rdPtr[PTR_W-1:0]].writeAbort;
	assign fileDest = s.file[s.rdPtr[PTR_W-1:0]].dest;
	assign fileFunc = s.file[s.rdPtr[PTR_W-1:0]].func;
	assign fileMask = s.file[s.rdPtr[PTR_W-1:0]].mask;
	assign fileId = s.file[s.rdPtr[PTR_W-1:0]].id;
	assign fileInfo = s.file[s.rdPtr[PTR_W-1:0]].info;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	sequence s_goodCmd;
		decide && s.pending == 2'h0 && isCmd && parOk && dest != brd_pkg::DST_NONE && funcOk;
	endsequence
	sequence s_noSpace;
		s_goodCmd ##0 !spaceOk;
	endsequence

	property p_latch;
		s.phase == brd_pkg::BRD_T3 |=> s.latInfo == $past(busInfo) && s.latTag == $past(busTag);
	endproperty
	a_latch: assert property (p_latch) else $error("bus not latched at T3");

	property p_cnfDrive;
		decide |-> ##4 confirmationCode == $past(next_s.cnfDecided, 4);
	endproperty
	a_cnfDrive: assert property (p_cnfDrive) else $error("confirmation not driven at T0");

	property p_busy;
		s_noSpace |-> ##4 confirmationCode == brd_pkg::CNF_BUSY;
	endproperty
	a_busy: assert property (p_busy) else $error("no busy on full file");

	property p_block;
		s_noSpace |=> s.block;
	endproperty
	a_block: assert property (p_block) else $error("block not set on busy");

	property p_blockHold;
		s.block && !popFire && decide |=> s.wrPtr == $past(s.wrPtr) || $past(s.pending) != 2'h0;
	endproperty
	a_blockHold: assert property (p_blockHold) else $error("file entry while blocked");

	property p_parAbort;
		decide && s.pending == 2'h0 && isCmd && !parOk |=> s.wrPtr == $past(s.wrPtr);
	endproperty
	a_parAbort: assert property (p_parAbort) else $error("bad command kept");

	property p_wdIgnore;
		decide && s.pending == 2'h0 && isWd |=> s.wrPtr == $past(s.wrPtr) ##3
			confirmationCode == brd_pkg::CNF_NORESP;
	endproperty
	a_wdIgnore: assert property (p_wdIgnore) else $error("stray write data answered");

	property p_xwmLoad;
		s_goodCmd ##0 (spaceOk && !s.block && funcCode == brd_pkg::FN_XWM) |=> s.pending == 2'h2;
	endproperty
	a_xwmLoad: assert property (p_xwmLoad) else $error("count not loaded with two");

	property p_ilkClear;
		decide && isWd && s.pending != 2'h0 && s.ilkClear |=> !s.interlock && !s.ilkClear;
	endproperty
	a_ilkClear: assert property (p_ilkClear) else $error("interlock not cleared");

	property p_noDest;
		decide && s.pending == 2'h0 && isCmd && parOk && dest == brd_pkg::DST_NONE
			|=> s.wrPtr == $past(s.wrPtr) ##3 confirmationCode == brd_pkg::CNF_NORESP;
	endproperty
	a_noDest: assert property (p_noDest) else $error("unknown address answered");

	property p_depth;
		fillCount <= DEPTH_L;
	endproperty
	a_depth: assert property (p_depth) else $error("file overfilled");
endmodule // brd_decoder
`default_nettype wire

// ==== brd_pkg.sv ====
// Operation
// - latch bus information lines every T3
// - parity check, tag, destination, function decode
// - confirmation set at T2, driven at T0
// - destination: array, configuration registers or ROM
// - busy when file cannot hold string
// - after space busy, block until entry leaves
// - nibble parity checked with two parity bits
// - bad command parity: abort, skip its data
// - bad write data parity: store with abort
// - only command and write data tags accepted
// - write data stored only while count nonzero
// - unexpected tag: store write abort, clear count
// - write counts one or two, decrement per data
// - function validity depends on destination
// - configuration writes need full mask
// - interlocked write arms interlock clear on data
// - keep requester identifier for reads
// - accepted command stored with decode results
// - file is four-entry first-in first-out
// - address bit 27 selects input/output space
// - unknown destination: no response, stop decode
// - invalid command: write pointer not advanced
`default_nettype none
package brd_pkg;
	localparam int INFO_W = 32;
	localparam int TAG_W = 3;
	localparam int ID_W = 5;
	localparam int MASK_W = 4;
	localparam int FUNC_W = 4;
	localparam int PAR_W = 2;
	localparam int ADDR_W = 28;
	localparam int NIBBLE_W = 4;
	localparam int CHK_W = INFO_W + TAG_W + ID_W + MASK_W;
	localparam int LOW_NIBBLES = 4;
	localparam int FUNC_LSB = 28;
	localparam int IO_SPACE_BIT = 27;
	localparam int CFG_SPAN_BITS = 6;
	localparam int ROM_SPAN_BITS = 12;
	localparam logic [TAG_W-1:0] TAG_CMD = 3'h3;
	localparam logic [TAG_W-1:0] TAG_WDATA = 3'h5;
	localparam logic [FUNC_W-1:0] FN_RM = 4'h1;
	localparam logic [FUNC_W-1:0] FN_WM = 4'h2;
	localparam logic [FUNC_W-1:0] FN_IRM = 4'h4;
	localparam logic [FUNC_W-1:0] FN_IWM = 4'h7;
	localparam logic [FUNC_W-1:0] FN_XR = 4'h8;
	localparam logic [FUNC_W-1:0] FN_XWM = 4'hb;
	localparam logic [MASK_W-1:0] MASK_ALL = 4'hf;
	localparam logic [1:0] CNF_NORESP = 2'h0;
	localparam logic [1:0] CNF_ACK = 2'h1;
	localparam logic [1:0] CNF_BUSY = 2'h2;
	localparam logic [1:0] CNF_ERR = 2'h3;
	localparam int APB_ADDR_W = 8;
	localparam logic [APB_ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [APB_ADDR_W-1:0] REG_ARRAY_BASE = 8'h04;
	localparam logic [APB_ADDR_W-1:0] REG_ARRAY_LIMIT = 8'h08;
	localparam logic [APB_ADDR_W-1:0] REG_CFG_BASE = 8'h0c;
	localparam logic [APB_ADDR_W-1:0] REG_ROM_BASE = 8'h10;
	localparam logic [APB_ADDR_W-1:0] REG_STATUS = 8'h14;
	localparam logic [APB_ADDR_W-1:0] REG_READ_ID = 8'h18;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	localparam logic [31:0] ARRAY_BASE_RESET = 32'h0000_0000;
	localparam logic [31:0] ARRAY_LIMIT_RESET = 32'h0010_0000;
	localparam logic [31:0] CFG_BASE_RESET = 32'h0000_0000;
	localparam logic [31:0] ROM_BASE_RESET = 32'h0000_1000;
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int ST_PEND_LSB = 0;
	localparam int ST_ILKCLR_BIT = 2;
	localparam int ST_ILK_BIT = 3;
	localparam int ST_BLOCK_BIT = 4;
	localparam int ST_COUNT_LSB = 8;
	localparam int ST_CNF_LSB = 12;

	typedef enum logic [1:0] {BRD_T0 = 2'h0, BRD_T1 = 2'h1, BRD_T2 = 2'h3, BRD_T3 = 2'h2} brd_phase_t;
	typedef enum logic [1:0] {DST_NONE = 2'h0, DST_ARRAY = 2'h1, DST_CFG = 2'h2, DST_ROM = 2'h3} brd_dest_t;
	typedef struct packed {
		logic isData;
		logic dataAbort;
		logic writeAbort;
		brd_dest_t dest;
		logic [FUNC_W-1:0] func;
		logic [MASK_W-1:0] mask;
		logic [ID_W-1:0] id;
		logic [INFO_W-1:0] info;
	} brd_entry_t;

	function automatic logic [1:0] brd_write_count(input logic [FUNC_W-1:0] f);
		case (f)
			FN_WM, FN_IWM: brd_write_count = 2'h1;
			FN_XWM: brd_write_count = 2'h2;
			default: brd_write_count = 2'h0;
		endcase
	endfunction

	function automatic logic brd_func_valid(input logic [FUNC_W-1:0] f, input brd_dest_t d,
		input logic [MASK_W-1:0] m);
		case (f)
			FN_RM, FN_IRM: brd_func_valid = (d != DST_NONE);
			FN_XR, FN_XWM: brd_func_valid = (d == DST_ARRAY);
			FN_WM, FN_IWM: brd_func_valid = (d == DST_ARRAY) || (d == DST_CFG && m == MASK_ALL);
			default: brd_func_valid = 1'b0;
		endcase
	endfunction
endpackage
`default_nettype wire

// ==== brd_testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench;
	localparam logic [27:0] ARR = 28'h0000100;
	localparam logic [27:0] CFG = 28'h8000010;
	localparam logic [27:0] ROM = 28'h8001004;
	localparam logic [27:0] NOD = 28'h0200000;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic fileReady = 1'b1;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [31:0] busInfo;
	logic [2:0] busTag;
	logic [4:0] busId;
	logic [3:0] busMask;
	logic [1:0] busParity;
	logic [1:0] busPhase;
	logic [1:0] confirmationCode;
	logic busFault;
	logic interlockFlag;
	logic fileValid;
	wire [49:0] head;
	logic [49:0] popQ[$];
	int fails = 0;
	int samples_checked = 0;
	int cyc = 0;
	brd_decoder #(.FILE_DEPTH(4)) brd_decoder_i (.mclk(mclk), .reset(reset), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .busInfo(busInfo), .busTag(busTag), .busId(busId),
		.busMask(busMask), .busParity(busParity), .busPhase(busPhase),
		.confirmationCode(confirmationCode), .busFault(busFault), .interlockFlag(interlockFlag),
		.fileValid(fileValid), .fileReady(fileReady), .fileIsData(head[49]),
		.fileDataAbort(head[48]), .fileWriteAbort(head[47]), .fileDest(head[46:45]),
		.fileFunc(head[44:41]), .fileMask(head[40:37]), .fileId(head[36:32]),
		.fileInfo(head[31:0]));
	brd_commander brd_commander_i (.mclk(mclk), .busPhase(busPhase),
		.confirmationCode(confirmationCode), .busFault(busFault), .busInfo(busInfo),
		.busTag(busTag), .busId(busId), .busMask(busMask), .busParity(busParity));
	initial begin
		forever #4 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (!reset && fileValid === 1'b1 && fileReady)
			popQ.push_back(head);
		if (cyc == 20000) begin
			fails = fails + 1;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input logic [49:0] got, input logic [49:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			fails++;
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic err);
		@(posedge mclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		{psel, penable} <= 2'h0;
	endtask
	task automatic cmd(input logic [3:0] fn, input logic [27:0] a, input logic [4:0] id,
		input logic [3:0] m, input logic [1:0] bad);
		brd_commander_i.add(brd_pkg::TAG_CMD, {fn, a}, id, m, bad);
	endtask
	task automatic dat(input logic [31:0] d, input logic [1:0] bad);
		brd_commander_i.add(brd_pkg::TAG_WDATA, d, 5'h00, 4'hf, bad);
	endtask
	task automatic go();
		brd_commander_i.run();
	endtask
	task automatic chk(input int k, input logic [1:0] c, input logic f);
		check({brd_commander_i.flt[k], brd_commander_i.cnf[k]}, {f, c});
	endtask
	task automatic noMore();
		check(50'(popQ.size()), 50'h0);
	endtask
	// data entries are judged only on flags, and on payload unless write-aborted
	task automatic pop(input logic [2:0] flg, input logic [1:0] dst, input logic [4:0] id,
		input logic [31:0] inf);
		logic [49:0] e;
		e = '0;
		if (popQ.size() > 0)
			e = popQ.pop_front();
		check(e[49:47], flg);
		if (!flg[2])
			check(e[46:0], {dst, inf[31:28], 4'hf, id, inf});
		else if (!flg[0])
			check(e[31:0], inf);
	endtask
	task automatic t_regs();
		logic [31:0] r;
		logic err;
		logic [7:0] a[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
		logic [31:0] v[7] = '{32'h1, 32'h0, 32'h0010_0000, 32'h0, 32'h1000, 32'h0, 32'h0};
		for (int k = 0; k < 7; k++) begin
			apb(1'b0, a[k], 32'h0, r, err);
			check({err, r}, {1'b0, v[k]});
		end
		apb(1'b0, 8'h40, 32'h0, r, err);
		check({err, r}, {1'b1, 32'h0});
		apb(1'b1, brd_pkg::REG_CTRL, 32'h0, r, err);
		cmd(brd_pkg::FN_RM, ARR, 5'h01, 4'hf, 2'h0);
		go();
		chk(0, 2'h0, 1'b0);
		noMore();
		apb(1'b1, brd_pkg::REG_CTRL, 32'h1, r, err);
		$display("register test done");
	endtask
	task automatic t_valid();
		logic [3:0] fn[4] = '{brd_pkg::FN_RM, brd_pkg::FN_WM, brd_pkg::FN_XR, brd_pkg::FN_XWM};
		logic [27:0] ad[4] = '{ARR, CFG, ROM, NOD};
		logic [1:0] ok;
		int nd;
		for (int f = 0; f < 4; f++) begin
			for (int d = 0; d < 4; d++) begin
				ok = (d == 3) ? 2'h0 : (f == 0 || d == 0 || (f == 1 && d == 1)) ? 2'h1 : 2'h3;
				nd = (ok != 2'h1) ? 0 : (f == 1) ? 1 : (f == 3) ? 2 : 0;
				cmd(fn[f], ad[d], 5'(d), 4'hf, 2'h0);
				for (int k = 0; k < nd; k++)
					dat(32'h5a00 + k, 2'h0);
				go();
				chk(0, ok, 1'b0);
				for (int k = 0; k < nd; k++)
					chk(k + 1, 2'h1, 1'b0);
				if (ok == 2'h1)
					pop(3'h0, 2'(d + 1), 5'(d), {fn[f], ad[d]});
				for (int k = 0; k < nd; k++)
					pop(3'h4, 2'h0, 5'h00, 32'h5a00 + k);
				noMore();
			end
		end
		$display("validity test done");
	endtask
	task automatic t_ilk();
		logic [31:0] r;
		logic err;
		cmd(brd_pkg::FN_IRM, ARR, 5'h07, 4'hf, 2'h0);
		cmd(brd_pkg::FN_IRM, ARR, 5'h08, 4'hf, 2'h0);
		cmd(brd_pkg::FN_IWM, CFG, 5'h09, 4'h7, 2'h0);
		go();
		chk(0, 2'h1, 1'b0);
		chk(1, 2'h2, 1'b0);
		chk(2, 2'h3, 1'b0);
		check(interlockFlag, 1'b1);
		apb(1'b0, brd_pkg::REG_READ_ID, 32'h0, r, err);
		check({err, r}, {1'b0, 32'h7});
		cmd(brd_pkg::FN_IWM, CFG, 5'h0a, 4'hf, 2'h0);
		dat(32'h1234, 2'h0);
		go();
		chk(0, 2'h1, 1'b0);
		chk(1, 2'h1, 1'b0);
		check(interlockFlag, 1'b0);
		pop(3'h0, 2'h1, 5'h07, {brd_pkg::FN_IRM, ARR});
		pop(3'h0, 2'h2, 5'h0a, {brd_pkg::FN_IWM, CFG});
		pop(3'h4, 2'h0, 5'h00, 32'h1234);
		noMore();
		$display("interlock test done");
	endtask
	task automatic t_par();
		cmd(brd_pkg::FN_RM, ARR, 5'h01, 4'hf, 2'h1);
		cmd(brd_pkg::FN_RM, ARR, 5'h02, 4'hf, 2'h2);
		cmd(brd_pkg::FN_WM, ARR, 5'h03, 4'hf, 2'h2);
		dat(32'h77, 2'h0);
		cmd(brd_pkg::FN_WM, ARR, 5'h04, 4'hf, 2'h0);
		dat(32'h88, 2'h1);
		go();
		chk(0, 2'h0, 1'b1);
		chk(1, 2'h0, 1'b1);
		chk(2, 2'h0, 1'b1);
		chk(3, 2'h0, 1'b0);
		chk(4, 2'h1, 1'b0);
		chk(5, 2'h1, 1'b1);
		pop(3'h0, 2'h1, 5'h04, {brd_pkg::FN_WM, ARR});
		pop(3'h6, 2'h0, 5'h00, 32'h88);
		noMore();
		$display("parity test done");
	endtask
	task automatic t_tags();
		logic [2:0] tg[6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6, 3'h7};
		for (int k = 0; k < 6; k++)
			brd_commander_i.add(tg[k], 32'h0, 5'h00, 4'h0, 2'h0);
		dat(32'h99, 2'h0);
		go();
		for (int k = 0; k < 6; k++)
			chk(k, 2'h0, 1'b0);
		chk(6, 2'h0, 1'b0);
		noMore();
		$display("tag test done");
	endtask
	task automatic t_abort();
		cmd(brd_pkg::FN_WM, ARR, 5'h05, 4'hf, 2'h0);
		cmd(brd_pkg::FN_RM, ARR, 5'h06, 4'hf, 2'h0);
		cmd(brd_pkg::FN_RM, ARR, 5'h07, 4'hf, 2'h0);
		go();
		chk(0, 2'h1, 1'b0);
		chk(1, 2'h0, 1'b0);
		chk(2, 2'h1, 1'b0);
		pop(3'h0, 2'h1, 5'h05, {brd_pkg::FN_WM, ARR});
		pop(3'h5, 2'h0, 5'h00, 32'h0);
		pop(3'h0, 2'h1, 5'h07, {brd_pkg::FN_RM, ARR});
		noMore();
		$display("abort test done");
	endtask
	task automatic t_full();
		fileReady <= 1'b0;
		for (int k = 1; k < 4; k++)
			cmd(brd_pkg::FN_RM, ARR, 5'(k), 4'hf, 2'h0);
		cmd(brd_pkg::FN_XWM, ARR, 5'h09, 4'hf, 2'h0);
		cmd(brd_pkg::FN_RM, ARR, 5'h04, 4'hf, 2'h0);
		go();
		for (int k = 0; k < 3; k++)
			chk(k, 2'h1, 1'b0);
		chk(3, 2'h2, 1'b0);
		chk(4, 2'h2, 1'b0);
		@(posedge mclk);
		fileReady <= 1'b1;
		@(posedge mclk);
		fileReady <= 1'b0;
		for (int k = 4; k < 7; k++)
			cmd(brd_pkg::FN_RM, ARR, 5'(k), 4'hf, 2'h0);
		go();
		chk(0, 2'h1, 1'b0);
		chk(1, 2'h1, 1'b0);
		chk(2, 2'h2, 1'b0);
		fileReady <= 1'b1;
		while (fileValid !== 1'b0)
			@(posedge mclk);
		for (int k = 1; k < 6; k++)
			pop(3'h0, 2'h1, 5'(k), {brd_pkg::FN_RM, ARR});
		noMore();
		$display("file test done");
	endtask
	task automatic t_rst();
		logic [31:0] r;
		logic err;
		fileReady <= 1'b0;
		// interlocked write leaves the interlock-clear flag armed and its command in the file
		cmd(brd_pkg::FN_IWM, ARR, 5'h0c, 4'hf, 2'h0);
		go();
		chk(0, 2'h1, 1'b0);
		reset <= 1'b1;
		@(posedge mclk);
		reset <= 1'b0;
		fileReady <= 1'b1;
		apb(1'b0, brd_pkg::REG_STATUS, 32'h0, r, err);
		check({fileValid, r}, 50'h0);
		noMore();
		$display("reset test done");
	endtask
	initial begin
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		t_regs();
		t_valid();
		t_ilk();
		t_par();
		t_tags();
		t_abort();
		t_full();
		t_rst();
		check(50'(brd_commander_i.strayCnf), 50'h0);
		summarize();
	end
endmodule // testbench
`default_nettype wire
